/* logic/printer_port_pkg.sv */
// Constants and shared types of the printer port register interface.
// Assumes one 50 MHz clock and a host that uses one-cycle strobes.
package printer_port_pkg;

    // ------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------
    localparam logic [1:0] PORT_DATA_OFFSET    = 2'h0;
    localparam logic [1:0] PORT_STATUS_OFFSET  = 2'h1;
    localparam logic [1:0] PORT_CONTROL_OFFSET = 2'h2;
    localparam logic [1:0] PORT_NONE_OFFSET    = 2'h3;

    // ------------------------------------------------------------
    // Reset values and field positions
    // ------------------------------------------------------------
    localparam logic [7:0] PORT_DATA_RESET    = 8'h00;
    localparam logic [5:0] PORT_CONTROL_RESET = 6'h00;
    localparam int CTRL_STROBE    = 0;
    localparam int CTRL_FEED      = 1;
    localparam int CTRL_INIT      = 2;
    localparam int CTRL_SELECT_IN = 3;
    localparam int CTRL_IRQ_EN    = 4;
    localparam int CTRL_DIR       = 5;
    localparam int SYNC_WIDTH     = 13;

    // ------------------------------------------------------------
    // Shared types
    // ------------------------------------------------------------
    typedef struct packed {
        logic       occupied;
        logic       acknowledge;
        logic       sheet_exhausted;
        logic       printer_selected;
        logic       fault;
        logic [7:0] parallel_data_pins;
    } printer_inputs_s;

    typedef struct packed {
        logic       mode;
        logic       interrupt_line_select;
        logic       enhanced_enable;
        logic       irq_status_option;
    } port_config_s;

endpackage

/* logic/pin_synchronizer.sv */
// Two-flop synchroniser for a group of pin inputs.
// Assumes the reset it receives is already released synchronously.
`timescale 1ns/1ps
module pin_synchronizer #(
    parameter int WIDTH = 8
) (
    // Clock and reset
    input  wire logic             clock_in,
    input  wire logic             rstn_in,
    // Pins and synchronised copy
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);
    typedef struct packed {
        logic [WIDTH-1:0] first;
        logic [WIDTH-1:0] second;
    } sync_state_s;

    sync_state_s state;
    sync_state_s next_state;

    // First stage is read only by the second
    always_comb begin
        next_state.first  = async_in;
        next_state.second = state.first;
    end

    always_ff @(posedge clock_in or negedge rstn_in) begin
        if (!rstn_in) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    assign sync_out = state.second;
endmodule

/* logic/printer_port.sv */
// Printer port register block: data, status and control registers.
// Assumes a host with one-cycle read and write strobes and external
// pad logic resolving every output enable into a wire level.
`timescale 1ns/1ps
module printer_port (
    // Clock and reset
    input  wire logic                            clock_in,
    input  wire logic                            rstn_in,
    // Host register port
    input  wire logic [1:0]                      address_in,
    input  wire logic                            read_in,
    input  wire logic                            write_in,
    input  wire logic [7:0]                      write_data_in,
    output logic      [7:0]                      read_data_out,
    output logic                                 read_data_oe_out,
    output logic                                 read_valid_out,
    // Configuration and enhanced sequencer
    input  wire printer_port_pkg::port_config_s  config_in,
    input  wire logic                            enhanced_timeout_in,
    // Printer pins
    input  wire printer_port_pkg::printer_inputs_s pins_in,
    output logic      [7:0]                      parallel_data_out,
    output logic                                 parallel_data_oe_out,
    output logic                                 data_strobe_out,
    output logic                                 auto_line_feed_out,
    output logic                                 select_in_out,
    output logic                                 strobe_group_oe_out,
    output logic                                 printer_reset_out,
    // Interrupt lines
    output logic      [1:0]                      port_interrupt_line_out,
    output logic      [1:0]                      port_interrupt_oe_out
);
    import printer_port_pkg::*;

    // ------------------------------------------------------------
    // Reset release
    // ------------------------------------------------------------
    logic [1:0] reset_sync;
    logic       rstn;

    always_ff @(posedge clock_in or negedge rstn_in) begin
        if (!rstn_in) begin
            reset_sync <= 2'b00;
        end else begin
            reset_sync <= {reset_sync[0], 1'b1};
        end
    end
    assign rstn = reset_sync[1];

    // ------------------------------------------------------------
    // Pin synchronisation
    // ------------------------------------------------------------
    printer_inputs_s pins;

    pin_synchronizer #(
        .WIDTH    (SYNC_WIDTH)
    ) u_sync (
        .clock_in (clock_in),
        .rstn_in  (rstn),
        .async_in (pins_in),
        .sync_out (pins)
    );

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        logic [7:0] data;
        logic [5:0] control;
        logic       control_written;
        logic       timeout_flag;
        logic       irq_pending;
        logic       ack_prev;
        logic       enhanced_prev;
        logic       irq_pulse;
        logic [7:0] read_data;
        logic       read_valid;
        logic       read_oe;
    } port_state_s;

    port_state_s state;
    port_state_s next_state;

    logic       extended;
    logic       enhanced;
    logic       compatible;
    logic       reverse;
    logic       ack_rise;
    logic       ack_fall;
    logic       status_read;
    logic       status_bit0;
    logic       status_bit2;
    logic       dir_read;
    logic       irq_level;
    logic [7:0] status_word;

    // ------------------------------------------------------------
    // Mode decode
    // ------------------------------------------------------------
    assign extended   = config_in.mode;
    assign enhanced   = config_in.enhanced_enable;
    assign compatible = !extended && !enhanced;
    assign reverse    = extended && state.control[CTRL_DIR];
    assign ack_rise   = pins.acknowledge && !state.ack_prev;
    assign ack_fall   = !pins.acknowledge && state.ack_prev;
    assign status_read = read_in && address_in == PORT_STATUS_OFFSET;

    // Timeout flag reads as one outside enhanced mode
    assign status_bit0 = enhanced ? state.timeout_flag : 1'b1;
    // Option bit only matters when not in extended mode
    assign status_bit2 = (extended
                          || (enhanced && config_in.irq_status_option))
                         ? !state.irq_pending : 1'b1;
    assign status_word = {!pins.occupied,
                          pins.acknowledge,
                          pins.sheet_exhausted,
                          pins.printer_selected,
                          pins.fault,
                          status_bit2,
                          1'b1,
                          status_bit0};
    // Direction bit is write-only outside enhanced mode
    assign dir_read = enhanced ? state.control[CTRL_DIR] : 1'b1;

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        next_state               = state;
        next_state.ack_prev      = pins.acknowledge;
        next_state.enhanced_prev = enhanced;
        next_state.read_valid    = read_in;
        next_state.read_oe       = 1'b0;
        next_state.irq_pulse     = 1'b0;

        // Writes: status offset and the empty offset are ignored
        if (write_in) begin
            unique case (address_in)
                PORT_DATA_OFFSET: begin
                    next_state.data = write_data_in;
                end
                PORT_CONTROL_OFFSET: begin
                    next_state.control         = write_data_in[5:0];
                    next_state.control_written = 1'b1;
                end
                PORT_STATUS_OFFSET: begin
                    next_state.data = state.data;
                end
                PORT_NONE_OFFSET: begin
                    next_state.data = state.data;
                end
            endcase
        end

        // Reads: data is registered, answered one cycle later
        if (read_in) begin
            next_state.read_oe = address_in != PORT_NONE_OFFSET;
            unique case (address_in)
                PORT_DATA_OFFSET: begin
                    next_state.read_data = reverse
                        ? pins.parallel_data_pins
                        : state.data;
                end
                PORT_STATUS_OFFSET: begin
                    next_state.read_data = status_word;
                end
                PORT_CONTROL_OFFSET: begin
                    next_state.read_data = {2'b11, dir_read,
                                            state.control[4:0]};
                end
                PORT_NONE_OFFSET: begin
                    next_state.read_data = 8'h00;
                end
            endcase
        end

        // Timeout flag: clear by read or enable rise, set wins
        if (status_read || (enhanced && !state.enhanced_prev)) begin
            next_state.timeout_flag = 1'b0;
        end
        if (enhanced && enhanced_timeout_in) begin
            next_state.timeout_flag = 1'b1;
        end

        // Interrupt status: read restores one, new edge wins
        if (status_read) begin
            next_state.irq_pending = 1'b0;
        end
        if (extended && state.control[CTRL_IRQ_EN] && ack_rise) begin
            next_state.irq_pending = 1'b1;
        end

        // Enhanced interrupt is a one-cycle pulse
        if (enhanced && (ack_fall || enhanced_timeout_in)) begin
            next_state.irq_pulse = 1'b1;
        end
    end

    always_ff @(posedge clock_in or negedge rstn) begin
        if (!rstn) begin
            state         <= '0;
            state.data    <= PORT_DATA_RESET;
            state.control <= PORT_CONTROL_RESET;
        end else begin
            state <= next_state;
        end
    end

    // ------------------------------------------------------------
    // Interrupt routing
    // ------------------------------------------------------------
    always_comb begin
        if (compatible) begin
            irq_level = !pins.acknowledge;
        end else if (enhanced) begin
            irq_level = state.irq_pulse;
        end else begin
            irq_level = state.irq_pending;
        end
    end

    // Disabled interrupt floats the selected line; other always floats
    assign port_interrupt_line_out = {irq_level, irq_level};
    assign port_interrupt_oe_out =
        state.control[CTRL_IRQ_EN]
            ? (config_in.interrupt_line_select ? 2'b10 : 2'b01)
            : 2'b00;

    // ------------------------------------------------------------
    // Pin and bus outputs
    // ------------------------------------------------------------
    assign parallel_data_out    = state.data;
    assign parallel_data_oe_out = !reverse;
    assign data_strobe_out      = !state.control[CTRL_STROBE];
    assign auto_line_feed_out   = !state.control[CTRL_FEED];
    assign select_in_out        = !state.control[CTRL_SELECT_IN];
    // Strobe group drivers stay off until software first writes the control register
    assign strobe_group_oe_out  = state.control_written;
    assign printer_reset_out    = state.control[CTRL_INIT];
    assign read_data_out        = state.read_data;
    assign read_data_oe_out     = state.read_oe;
    assign read_valid_out       = state.read_valid;
endmodule

/* tb/printer_port_chk.sv */
// Checker for the printer port register block, bound to printer_port.
// Assumes it sees only that module's ports and one clock domain.
`timescale 1ns/1ps
module printer_port_chk
    import printer_port_pkg::*;
(
    // Watched ports
    input wire logic         clock_in, rstn_in, read_in, write_in,
    input wire logic [1:0]   address_in,
    input wire logic [7:0]   write_data_in, read_data_out, parallel_data_out,
    input wire logic         read_data_oe_out, read_valid_out,
    input wire logic         data_strobe_out, auto_line_feed_out,
    input wire logic         select_in_out, strobe_group_oe_out,
    input wire logic         printer_reset_out,
    input wire logic [1:0]   port_interrupt_oe_out,
    input wire port_config_s config_in
);
    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge clock_in); endclocking
    default disable iff (!rstn_in);
    logic [7:0] wd_q;
    logic       wr_c;
    assign wr_c = write_in && address_in == 2'h2;
    // Write data of the previous cycle, so pin checks need no sampled bit selects
    always_ff @(posedge clock_in) wd_q <= write_data_in;

    // Skips the first edge in reset, where outputs may still be unknown
    reset_state_a: assert property (disable iff (1'b0)
        !rstn_in && $past(!rstn_in) |-> !printer_reset_out &&
        !strobe_group_oe_out &&
        port_interrupt_oe_out == 2'h0) else $error("reset state wrong");
    read_answer_a: assert property (read_in |=> read_valid_out)
        else $error("read not answered");
    stray_valid_a: assert property (!read_in |=> !read_valid_out)
        else $error("stray read valid");
    none_float_a: assert property (read_in && address_in == 2'h3 |=>
        !read_data_oe_out && read_data_out == 8'h00) else $error("addr 3");
    bus_drive_a: assert property (read_in && address_in != 2'h3 |=>
        read_data_oe_out) else $error("bus not driven");
    data_latch_a: assert property (write_in && address_in == 2'h0 |=>
        parallel_data_out == wd_q) else $error("data latch");
    ctrl_pins_a: assert property (wr_c |=> strobe_group_oe_out &&
        {select_in_out, auto_line_feed_out, data_strobe_out} ==
        ~{wd_q[3], wd_q[1:0]}) else $error("control pins");
    init_follow_a: assert property (wr_c |=> printer_reset_out == wd_q[2])
        else $error("init pin");
    ctrl_upper_a: assert property (read_in && address_in == 2'h2 |=>
        read_data_out[7:6] == 2'h3) else $error("control upper bits");
    status_fixed_a: assert property (read_in && address_in == 2'h1 &&
        !config_in.enhanced_enable |=> read_data_out[1:0] == 2'h3)
        else $error("status low bits");
    status_ro_a: assert property (write_in && address_in == 2'h1 |=>
        $stable(parallel_data_out) && $stable(printer_reset_out))
        else $error("status write had effect");
    irq_route_a: assert property ($stable(config_in) &&
        |port_interrupt_oe_out |-> port_interrupt_oe_out ==
        (config_in.interrupt_line_select ? 2'h2 : 2'h1)) else $error("irq");
    cover property (read_in && address_in == 2'h1 ##1 !read_data_out[2]);
    cover property (|port_interrupt_oe_out);
    cover property (wr_c && write_data_in[5] && config_in.mode);
endmodule
bind printer_port printer_port_chk chk_u (.clock_in, .rstn_in, .read_in,
    .write_in, .address_in, .write_data_in, .read_data_out,
    .parallel_data_out, .read_data_oe_out, .read_valid_out, .data_strobe_out,
    .auto_line_feed_out, .select_in_out, .strobe_group_oe_out,
    .printer_reset_out, .port_interrupt_oe_out, .config_in);

/* tb/printer_model.sv */
// Printer on the far end of the cable: acknowledges each strobe.
// Assumes it shares the port clock; the bench sets the ack delay.
`timescale 1ns/1ps
module printer_model
    import printer_port_pkg::*;
(
    // Port side
    input  wire logic [7:0] parallel_data_out,
    input  wire logic       clock_in, parallel_data_oe_out,
    input  wire logic       data_strobe_out, strobe_group_oe_out,
    // Bench side
    input  wire logic [7:0] peri_data_in, ack_delay_in,
    input  wire logic       peri_drive_in,
    input  wire logic [3:0] lines_in,
    output printer_inputs_s pins_out
);
    logic       strobe_q = 1'b1;
    logic [7:0] last = 8'h00;
    int         count = 0;
    logic       strobe_n;
    logic [7:0] data;
    assign strobe_n = data_strobe_out | !strobe_group_oe_out;
    // Nobody driving: pattern changes every cycle, never a held value
    assign data = parallel_data_oe_out ? parallel_data_out
                : peri_drive_in ? peri_data_in : ~last;
    assign pins_out = {lines_in[3], !(count inside {[1:4]}), lines_in[2:0],
                       data};
    always @(posedge clock_in) begin
        strobe_q <= strobe_n;
        last <= data;
        if (strobe_q && !strobe_n) begin
            count <= int'(ack_delay_in) + 4;
        end else if (count > 0) begin
            count <= count - 1;
        end
    end
endmodule

/* tb/tb_printer_port.sv */
// Self-checking bench for printer_port with a reference model.
// Assumes the package and design are compiled first.
`timescale 1ns/1ps
module tb_printer_port;
    import printer_port_pkg::*;
    logic            clock_in, rstn_in, read_in, write_in, enhanced_timeout_in;
    logic            read_data_oe_out, read_valid_out, parallel_data_oe_out;
    logic            data_strobe_out, auto_line_feed_out, select_in_out;
    logic            strobe_group_oe_out, printer_reset_out, peri_drive;
    logic [1:0]      address_in, port_interrupt_line_out, port_interrupt_oe_out;
    logic [7:0]      write_data_in, read_data_out, parallel_data_out;
    logic [7:0]      peri_data, ack_delay, d;
    logic [3:0]      lines;
    port_config_s    config_in;
    printer_inputs_s pins;
    int              miscompares, samples_checked, exp_data, exp_ctrl;
    int              pending, tflag;

    printer_port dut_u (.clock_in, .rstn_in, .address_in, .read_in,
        .write_in, .write_data_in, .read_data_out, .read_data_oe_out,
        .read_valid_out, .config_in, .enhanced_timeout_in, .pins_in(pins),
        .parallel_data_out, .parallel_data_oe_out, .data_strobe_out,
        .auto_line_feed_out, .select_in_out, .strobe_group_oe_out,
        .printer_reset_out, .port_interrupt_line_out, .port_interrupt_oe_out);
    printer_model printer_u (.parallel_data_out, .clock_in,
        .parallel_data_oe_out, .data_strobe_out, .strobe_group_oe_out,
        .peri_data_in(peri_data), .ack_delay_in(ack_delay),
        .peri_drive_in(peri_drive), .lines_in(lines), .pins_out(pins));

    // ------------------------------------------------------------
    // Tasks and reference model
    // ------------------------------------------------------------
    task automatic cmp(input string what, input logic [7:0] e, g);
        samples_checked++;
        if (g !== e) begin
            miscompares++;
            $display("mismatch %s expected %h seen %h", what, e, g);
        end
    endtask
    task automatic wr(input logic [1:0] a, input logic [7:0] v);
        @(posedge clock_in) #1;
        {write_in, address_in, write_data_in} = {1'b1, a, v};
        @(posedge clock_in) #1;
        write_in = 0;
        if (a == 2'h0) exp_data = v;
        if (a == 2'h2) exp_ctrl = v;
    endtask
    task automatic rd(input logic [1:0] a, input logic [7:0] e);
        @(posedge clock_in) #1;
        {read_in, address_in} = {1'b1, a};
        @(posedge clock_in) #1;
        read_in = 0;
        cmp("read_valid", 8'h01, {7'h00, read_valid_out});
        cmp($sformatf("reg%0d", a), e, read_data_out);
        if (a == 2'h1) {pending, tflag} = 0;
    endtask
    // Status expectation: bit 2 is the flag only in the flag modes
    function automatic logic [7:0] st_exp();
        logic f;
        f = config_in.mode |
            (config_in.enhanced_enable & config_in.irq_status_option);
        return {~lines[3], 1'b1, lines[2:0], ~(f & pending[0]), 1'b1,
                config_in.enhanced_enable ? tflag[0] : 1'b1};
    endfunction
    task automatic tally_and_finish();
        $display("checked %0d mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // ------------------------------------------------------------
    // Clock, watchdog and tests
    // ------------------------------------------------------------
    initial begin
        clock_in = 0;
        forever #10 clock_in = ~clock_in;
    end
    initial begin
        repeat (5000) @(posedge clock_in);
        miscompares++;
        tally_and_finish();
    end
    initial begin
        {rstn_in, read_in, write_in, enhanced_timeout_in, peri_drive} = 0;
        {address_in, write_data_in, peri_data, lines, config_in} = 0;
        {exp_data, exp_ctrl, pending, tflag, miscompares, samples_checked} = 0;
        ack_delay = 8'h01;
        void'($urandom(34018));
        repeat (5) @(posedge clock_in) #1;
        rstn_in = 1;
        repeat (5) @(posedge clock_in) #1;
        rd(2'h0, 8'h00);
        rd(2'h2, 8'he0);
        cmp("init_pin", 8'h00, {7'h00, printer_reset_out});
        $display("test reset done");
        wr(2'h0, 8'($urandom));
        cmp("pins", exp_data[7:0], parallel_data_out);
        wr(2'h1, ~exp_data[7:0]);
        rd(2'h0, exp_data[7:0]);
        rd(2'h3, 8'h00);
        cmp("bus_oe", 8'h00, {7'h00, read_data_oe_out});
        for (int i = 0; i < 4; i++) begin
            lines = 4'($urandom);
            repeat (4) @(posedge clock_in) #1;
            rd(2'h1, st_exp());
        end
        $display("test compatible done");
        // Strobe bit kept clear so the printer stays idle here
        for (int i = 0; i < 4; i++) begin
            config_in.interrupt_line_select = i[0];
            d = 8'($urandom) & 8'h3e;
            wr(2'h2, d);
            cmp("ctl_pins", {4'h0, ~d[3], d[2], ~d[1], 1'b1}, {4'h0,
                select_in_out, printer_reset_out, auto_line_feed_out,
                data_strobe_out});
            cmp("irq_oe", d[4] ? 8'(i[0] + 1) : 8'h00,
                {6'h00, port_interrupt_oe_out});
            cmp("irq_lvl", 8'h00, {6'h00, port_interrupt_line_out});
            rd(2'h2, {3'h7, d[4:0]});
        end
        $display("test control done");
        config_in.mode = 1;
        wr(2'h2, 8'h24);
        wr(2'h0, 8'($urandom));
        {peri_drive, peri_data} = {1'b1, ~exp_data[7:0]};
        cmp("data_oe", 8'h00, {7'h00, parallel_data_oe_out});
        repeat (3) @(posedge clock_in) #1;
        rd(2'h0, peri_data);
        peri_drive = 0;
        wr(2'h2, 8'h04);
        cmp("data_oe", 8'h01, {7'h00, parallel_data_oe_out});
        rd(2'h0, exp_data[7:0]);
        config_in.interrupt_line_select = 1;
        for (int i = 0; i < 2; i++) begin
            ack_delay = 8'(i * 8 + 1);
            wr(2'h2, 8'h15);
            wr(2'h2, 8'h14);
            repeat (24) @(posedge clock_in) #1;
            pending = 1;
            cmp("irq_ext", 8'h01, {7'h00, port_interrupt_line_out[1]});
            rd(2'h1, st_exp());
            rd(2'h1, st_exp());
        end
        $display("test extended done");
        config_in.mode = 0;
        // Interrupt enable kept clear before the enhanced mode is entered
        wr(2'h2, 8'h04);
        config_in.enhanced_enable = 1;
        @(posedge clock_in) #1;
        enhanced_timeout_in = 1;
        @(posedge clock_in) #1;
        enhanced_timeout_in = 0;
        cmp("irq_pulse", 8'h03, {6'h00, port_interrupt_line_out});
        tflag = 1;
        rd(2'h1, st_exp());
        rd(2'h1, st_exp());
        rd(2'h2, 8'hc4);
        $display("test enhanced done");
        wr(2'h0, 8'h5a);
        rstn_in = 0;
        repeat (2) @(posedge clock_in) #1;
        rstn_in = 1;
        repeat (5) @(posedge clock_in) #1;
        rd(2'h0, 8'h00);
        $display("test second reset done");
        tally_and_finish();
    end
endmodule
